// ---- adm_pkg.sv ----
// constants, register map and lookup tables for the audio decoder status and mix registers
package adm_pkg;

	// register indices on the control port
	localparam logic [7:0] ADM_ADDR_ANC_LOW   = 8'h41;
	localparam logic [7:0] ADM_ADDR_ANC_HIGH  = 8'h42;
	localparam logic [7:0] ADM_ADDR_HDR_UPPER = 8'h43;
	localparam logic [7:0] ADM_ADDR_HDR_MID   = 8'h44;
	localparam logic [7:0] ADM_ADDR_HDR_LOWER = 8'h45;
	localparam logic [7:0] ADM_ADDR_LDIR      = 8'h46;
	localparam logic [7:0] ADM_ADDR_LXR       = 8'h47;
	localparam logic [7:0] ADM_ADDR_RDIR      = 8'h48;
	localparam logic [7:0] ADM_ADDR_RXL       = 8'h49;
	localparam logic [7:0] ADM_ADDR_PLL_DIV   = 8'h50;
	localparam logic [7:0] ADM_ADDR_PLL_FRACL = 8'h51;

	// reset values
	localparam logic [7:0] ADM_RST_ZERO  = 8'h00;
	localparam logic [7:0] ADM_RST_CROSS = 8'hff;
	localparam logic [7:0] ADM_RD_ZERO   = 8'h00;

	// header field positions and widths
	localparam int ADM_HDR_W      = 21;
	localparam int ADM_HDR_EMPH   = 0;
	localparam int ADM_HDR_ORIG   = 2;
	localparam int ADM_HDR_COPY   = 3;
	localparam int ADM_HDR_MEXT   = 4;
	localparam int ADM_HDR_MODE   = 6;
	localparam int ADM_HDR_PRIV   = 8;
	localparam int ADM_HDR_PAD    = 9;
	localparam int ADM_HDR_SFREQ  = 10;
	localparam int ADM_HDR_BRATE  = 12;
	localparam int ADM_HDR_PROT   = 16;
	localparam int ADM_HDR_LAYER  = 17;
	localparam int ADM_HDR_VER    = 19;
	localparam int ADM_HDR_EXTVER = 20;
	localparam int ADM_PLL_DIV_W  = 5;

	// field codes
	localparam logic [1:0] ADM_LAYER_III     = 2'h1;
	localparam logic [3:0] ADM_BR_FREE       = 4'h0;
	localparam logic [3:0] ADM_BR_FORBIDDEN  = 4'hf;
	localparam logic [1:0] ADM_VER_MPEG25    = 2'h0;
	localparam logic [1:0] ADM_VER_RESERVED  = 2'h1;
	localparam logic [1:0] ADM_VER_MPEG2     = 2'h2;
	localparam logic [1:0] ADM_VER_MPEG1     = 2'h3;
	localparam logic [1:0] ADM_SF_RESERVED   = 2'h3;
	localparam logic [1:0] ADM_MODE_JOINT    = 2'h1;
	localparam logic [1:0] ADM_EMPH_RESERVED = 2'h2;

	// bitrate in kbit/s, entry 0 is free format, entry 15 forbidden
	localparam logic [15:0][8:0] ADM_BR_V1 = {9'h000, 9'h140, 9'h100, 9'h0e0, 9'h0c0, 9'h0a0, 9'h080,
		9'h070, 9'h060, 9'h050, 9'h040, 9'h038, 9'h030, 9'h028, 9'h020, 9'h000};
	localparam logic [15:0][8:0] ADM_BR_V0 = {9'h000, 9'h0a0, 9'h090, 9'h080, 9'h070, 9'h060, 9'h050,
		9'h040, 9'h038, 9'h030, 9'h028, 9'h020, 9'h018, 9'h010, 9'h008, 9'h000};

	// base sampling rates in Hz for the first version, entry 3 reserved
	localparam logic [3:0][15:0] ADM_SF_BASE = {16'h0000, 16'h7d00, 16'hbb80, 16'hac44};

	// attenuation: one dB per unit, six dB taken as one halving
	localparam logic [7:0] ADM_ATT_MAX_DB  = 8'h60;
	localparam logic [7:0] ADM_DB_PER_HALF = 8'h06;
	localparam int         ADM_GAIN_FRAC   = 15;
	localparam logic [5:0][15:0] ADM_GAIN_STEP = {16'h47fb, 16'h50c3, 16'h5a9e, 16'h65ad, 16'h7215, 16'h8000};

endpackage

// ---- adm_attenuator.sv ----
// one attenuator path: scales a signed sample by a 1 dB step code, registered output
module adm_attenuator
	import adm_pkg::*;
#(
	parameter int W = 16
) (
	input  wire logic                core_clk,
	input  wire logic                sys_rst,
	input  wire logic signed [W-1:0] sample,
	input  wire logic [7:0]          att_code,
	output logic signed [W-1:0]      scaled
);

	logic [7:0]              halvings;
	logic [7:0]              step_idx;
	logic [15:0]             step_gain;
	logic signed [W+16:0]    product;
	logic signed [W+16:0]    shifted;
	logic                    mute;
	logic signed [W-1:0]     nxt_scaled;

	// split the code into whole halvings and a fine step below 6 dB
	assign halvings  = att_code / ADM_DB_PER_HALF;
	assign step_idx  = att_code % ADM_DB_PER_HALF;
	assign step_gain = ADM_GAIN_STEP[step_idx[2:0]];
	// codes past the table, 0xff included, silence the path fully
	assign mute      = (att_code > ADM_ATT_MAX_DB);
	assign product   = sample * $signed({1'b0, step_gain});
	// gain never exceeds one, so the low W bits of the shift hold the result
	assign shifted   = product >>> (ADM_GAIN_FRAC + int'(halvings));
	assign nxt_scaled = mute ? '0 : shifted[W-1:0];

	// registered so the multiplier does not chain into the mixer adder
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst)
			scaled <= '0;
		else
			scaled <= nxt_scaled;
	end

endmodule

// ---- adm_status_mix_regs.sv ----
// status, header capture, butterfly mixer and pll divider registers of the audio decoder
module adm_status_mix_regs
	import adm_pkg::*;
#(
	parameter int PCM_W = 16
) (
	input  wire logic                    core_clk,
	input  wire logic                    sys_rst,
	input  wire logic                    soft_rst,
	input  wire logic [7:0]              reg_addr,
	input  wire logic                    reg_wr,
	input  wire logic [7:0]              reg_wdata,
	input  wire logic                    reg_rd,
	output logic [7:0]                   reg_rdata,
	input  wire logic                    frame_sync,
	input  wire logic [ADM_HDR_W-1:0]    frame_header_in,
	input  wire logic                    frame_ok,
	input  wire logic [15:0]             anc_bits_in,
	input  wire logic [7:0]              pll_fraction_44k1_high,
	input  wire logic                    pcm_in_valid,
	input  wire logic signed [PCM_W-1:0] pcm_in_left,
	input  wire logic signed [PCM_W-1:0] pcm_in_right,
	output logic                         pcm_out_valid,
	output logic signed [PCM_W-1:0]      pcm_out_left,
	output logic signed [PCM_W-1:0]      pcm_out_right,
	output logic [ADM_PLL_DIV_W-1:0]     pll_out_divider_44k1,
	output logic [ADM_PLL_DIV_W:0]       pll_divide_ratio,
	output logic [15:0]                  pll_fraction_44k1,
	output logic [8:0]                   hdr_bitrate_kbps,
	output logic                         hdr_free_format,
	output logic                         hdr_bitrate_forbidden,
	output logic [1:0]                   hdr_version,
	output logic                         hdr_version_reserved,
	output logic [15:0]                  hdr_sample_rate_hz,
	output logic                         hdr_sample_rate_reserved,
	output logic                         hdr_layer3_ok,
	output logic                         hdr_crc_present,
	output logic                         hdr_padding,
	output logic                         hdr_private,
	output logic [1:0]                   hdr_mode,
	output logic                         hdr_mode_ext_valid,
	output logic [1:0]                   hdr_mode_ext,
	output logic                         hdr_copyright,
	output logic                         hdr_original,
	output logic [1:0]                   hdr_emphasis,
	output logic                         hdr_emphasis_reserved
);

	// status and configuration storage
	logic [15:0]              anc_count_ff;
	logic [ADM_HDR_W-1:0]     header_ff;
	logic [7:0]               left_direct_attenuation_ff;
	logic [7:0]               left_to_right_cross_attenuation_ff;
	logic [7:0]               right_direct_attenuation_ff;
	logic [7:0]               right_to_left_cross_attenuation_ff;
	logic [ADM_PLL_DIV_W-1:0] pll_out_divider_44k1_ff;
	logic [7:0]               pll_fraction_44k1_low_ff;
	logic [7:0]               rdata_ff;

	// register port decode
	logic wr_ldir;
	logic wr_lxr;
	logic wr_rdir;
	logic wr_rxl;
	logic wr_pll_div;
	logic wr_pll_fracl;
	logic [7:0] nxt_rdata;

	// one index per strobe
	assign wr_ldir      = reg_wr && (reg_addr == ADM_ADDR_LDIR);
	assign wr_lxr       = reg_wr && (reg_addr == ADM_ADDR_LXR);
	assign wr_rdir      = reg_wr && (reg_addr == ADM_ADDR_RDIR);
	assign wr_rxl       = reg_wr && (reg_addr == ADM_ADDR_RXL);
	assign wr_pll_div   = reg_wr && (reg_addr == ADM_ADDR_PLL_DIV);
	assign wr_pll_fracl = reg_wr && (reg_addr == ADM_ADDR_PLL_FRACL);

	// header bytes as read
	wire [7:0] hdr_byte_upper = 8'(header_ff[ADM_HDR_W-1:ADM_HDR_PROT]);
	wire [7:0] hdr_byte_mid   = header_ff[ADM_HDR_PROT-1:ADM_HDR_PRIV];
	wire [7:0] hdr_byte_lower = header_ff[ADM_HDR_PRIV-1:ADM_HDR_EMPH];

	// read mux; status registers ignore writes, unmapped indices read zero
	// full decode, no aliases
	always_comb begin
		nxt_rdata = ADM_RD_ZERO;
		unique case (reg_addr)
			ADM_ADDR_ANC_LOW:   nxt_rdata = anc_count_ff[7:0];
			ADM_ADDR_ANC_HIGH:  nxt_rdata = anc_count_ff[15:8];
			ADM_ADDR_HDR_UPPER: nxt_rdata = hdr_byte_upper;
			ADM_ADDR_HDR_MID:   nxt_rdata = hdr_byte_mid;
			ADM_ADDR_HDR_LOWER: nxt_rdata = hdr_byte_lower;
			ADM_ADDR_LDIR:      nxt_rdata = left_direct_attenuation_ff;
			ADM_ADDR_LXR:       nxt_rdata = left_to_right_cross_attenuation_ff;
			ADM_ADDR_RDIR:      nxt_rdata = right_direct_attenuation_ff;
			ADM_ADDR_RXL:       nxt_rdata = right_to_left_cross_attenuation_ff;
			ADM_ADDR_PLL_DIV:   nxt_rdata = {3'h0, pll_out_divider_44k1_ff};
			ADM_ADDR_PLL_FRACL: nxt_rdata = pll_fraction_44k1_low_ff;
			default:            nxt_rdata = ADM_RD_ZERO;
		endcase
	end

	// read data is held until the next read strobe
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst)
			rdata_ff <= ADM_RD_ZERO;
		else if (reg_rd)
			rdata_ff <= nxt_rdata;
	end

	// port shows held byte
	assign reg_rdata = rdata_ff;

	// ancillary count is taken only when a frame decodes correctly
	// bad frames keep old count
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst)
			anc_count_ff <= {ADM_RST_ZERO, ADM_RST_ZERO};
		else if (soft_rst)
			anc_count_ff <= {ADM_RST_ZERO, ADM_RST_ZERO};
		else if (frame_ok)
			anc_count_ff <= anc_bits_in;
	end

	// all three header bytes load in one edge so a read never mixes two frames
	// layer is not checked here
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst)
			header_ff <= '0;
		else if (soft_rst)
			header_ff <= '0;
		else if (frame_sync)
			header_ff <= frame_header_in;
	end

	// direct attenuators start open, cross ones start fully closed
	// soft reset beats a write
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			left_direct_attenuation_ff         <= ADM_RST_ZERO;
			right_direct_attenuation_ff        <= ADM_RST_ZERO;
			left_to_right_cross_attenuation_ff <= ADM_RST_CROSS;
			right_to_left_cross_attenuation_ff <= ADM_RST_CROSS;
		end else if (soft_rst) begin
			left_direct_attenuation_ff         <= ADM_RST_ZERO;
			right_direct_attenuation_ff        <= ADM_RST_ZERO;
			left_to_right_cross_attenuation_ff <= ADM_RST_CROSS;
			right_to_left_cross_attenuation_ff <= ADM_RST_CROSS;
		end else begin
			if (wr_ldir)
				left_direct_attenuation_ff <= reg_wdata;
			if (wr_lxr)
				left_to_right_cross_attenuation_ff <= reg_wdata;
			if (wr_rdir)
				right_direct_attenuation_ff <= reg_wdata;
			if (wr_rxl)
				right_to_left_cross_attenuation_ff <= reg_wdata;
		end
	end

	// pll settings; divider bits above the five-bit field are not stored
	// high byte lives outside
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pll_out_divider_44k1_ff  <= '0;
			pll_fraction_44k1_low_ff <= ADM_RST_ZERO;
		end else if (soft_rst) begin
			pll_out_divider_44k1_ff  <= '0;
			pll_fraction_44k1_low_ff <= ADM_RST_ZERO;
		end else begin
			if (wr_pll_div)
				pll_out_divider_44k1_ff <= reg_wdata[ADM_PLL_DIV_W-1:0];
			if (wr_pll_fracl)
				pll_fraction_44k1_low_ff <= reg_wdata;
		end
	end

	// pll view for the clock generator, used only in the 44.1 kHz family
	// ratio is combinational
	assign pll_out_divider_44k1 = pll_out_divider_44k1_ff;
	assign pll_divide_ratio     = {1'b0, pll_out_divider_44k1_ff} + 1'b1;
	assign pll_fraction_44k1    = {pll_fraction_44k1_high, pll_fraction_44k1_low_ff};

	// header field slices
	wire [1:0] f_emph   = header_ff[ADM_HDR_EMPH+:2];
	wire [1:0] f_mode   = header_ff[ADM_HDR_MODE+:2];
	wire [1:0] f_mext   = header_ff[ADM_HDR_MEXT+:2];
	wire [1:0] f_sfreq  = header_ff[ADM_HDR_SFREQ+:2];
	wire [3:0] f_brate  = header_ff[ADM_HDR_BRATE+:4];
	wire [1:0] f_layer  = header_ff[ADM_HDR_LAYER+:2];
	wire [1:0] f_ver    = {header_ff[ADM_HDR_EXTVER], header_ff[ADM_HDR_VER]};

	// rate before version scaling
	wire [15:0] sf_base = ADM_SF_BASE[f_sfreq];

	// single-bit flags straight from the captured header
	assign hdr_original  = header_ff[ADM_HDR_ORIG];
	assign hdr_copyright = header_ff[ADM_HDR_COPY];
	assign hdr_private   = header_ff[ADM_HDR_PRIV];
	assign hdr_padding   = header_ff[ADM_HDR_PAD];

	// a clear protection bit means a checksum word follows the header
	assign hdr_crc_present = ~header_ff[ADM_HDR_PROT];

	// flag reports layer III only
	assign hdr_layer3_ok   = (f_layer == ADM_LAYER_III);

	// mode and its extension; the extension is masked outside joint stereo
	assign hdr_mode           = f_mode;
	assign hdr_mode_ext_valid = (f_mode == ADM_MODE_JOINT);
	assign hdr_mode_ext       = hdr_mode_ext_valid ? f_mext : 2'h0;

	// de-emphasis selection
	// reserved is flagged only
	assign hdr_emphasis          = f_emph;
	assign hdr_emphasis_reserved = (f_emph == ADM_EMPH_RESERVED);

	// bitrate picks its table from the version bit alone
	assign hdr_free_format       = (f_brate == ADM_BR_FREE);
	assign hdr_bitrate_forbidden = (f_brate == ADM_BR_FORBIDDEN);
	// 1111 reads zero; see flag
	assign hdr_bitrate_kbps      = header_ff[ADM_HDR_VER] ? ADM_BR_V1[f_brate]
		: ADM_BR_V0[f_brate];

	// sampling rate halves per version step down; 11.025 kHz comes out exact
	assign hdr_version          = f_ver;
	assign hdr_version_reserved = (f_ver == ADM_VER_RESERVED);
	assign hdr_sample_rate_reserved = (f_sfreq == ADM_SF_RESERVED)
		|| hdr_version_reserved;

	// reserved reads zero
	always_comb begin
		hdr_sample_rate_hz = 16'h0000;
		unique case (f_ver)
			ADM_VER_MPEG1:    hdr_sample_rate_hz = sf_base;
			ADM_VER_MPEG2:    hdr_sample_rate_hz = sf_base >> 1;
			ADM_VER_MPEG25:   hdr_sample_rate_hz = sf_base >> 2;
			ADM_VER_RESERVED: hdr_sample_rate_hz = 16'h0000;
		endcase
	end

	// butterfly paths: 0 left direct, 1 right-to-left, 2 right direct, 3 left-to-right
	logic signed [PCM_W-1:0] path_in  [4];
	logic [7:0]              path_att [4];
	logic signed [PCM_W-1:0] path_out [4];

	// left: own left, cross right
	assign path_in[0]  = pcm_in_left;
	assign path_att[0] = left_direct_attenuation_ff;
	assign path_in[1]  = pcm_in_right;
	assign path_att[1] = right_to_left_cross_attenuation_ff;

	// right: own right, cross left
	assign path_in[2]  = pcm_in_right;
	assign path_att[2] = right_direct_attenuation_ff;
	assign path_in[3]  = pcm_in_left;
	assign path_att[3] = left_to_right_cross_attenuation_ff;

	// one attenuator per path of the butterfly
	for (genvar p = 0; p < 4; p++) begin : g_path
		adm_attenuator #(
			.W (PCM_W)
		) u_att (
			.core_clk (core_clk),
			.sys_rst  (sys_rst),
			.sample   (path_in[p]),
			.att_code (path_att[p]),
			.scaled   (path_out[p])
		);
	end

	// each output sums its two paths; clipping beats wraparound on full-scale mixes
	logic signed [PCM_W:0]   sum_left;
	logic signed [PCM_W:0]   sum_right;
	logic signed [PCM_W-1:0] nxt_left;
	logic signed [PCM_W-1:0] nxt_right;
	localparam logic signed [PCM_W-1:0] PCM_MAX = {1'b0, {(PCM_W-1){1'b1}}};
	localparam logic signed [PCM_W-1:0] PCM_MIN = {1'b1, {(PCM_W-1){1'b0}}};

	// one guard bit for two paths
	assign sum_left  = (PCM_W+1)'(path_out[0])
		+ (PCM_W+1)'(path_out[1]);
	assign sum_right = (PCM_W+1)'(path_out[2])
		+ (PCM_W+1)'(path_out[3]);
	assign nxt_left  = (sum_left[PCM_W] == sum_left[PCM_W-1]) ? sum_left[PCM_W-1:0]
		: (sum_left[PCM_W] ? PCM_MIN : PCM_MAX);
	assign nxt_right = (sum_right[PCM_W] == sum_right[PCM_W-1]) ? sum_right[PCM_W-1:0]
		: (sum_right[PCM_W] ? PCM_MIN : PCM_MAX);

	// valid follows the two pipeline stages: attenuator, then adder
	logic valid_s1_ff;
	logic valid_s2_ff;

	// soft reset spares the pipe
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			valid_s1_ff <= 1'b0;
			valid_s2_ff <= 1'b0;
		end else begin
			valid_s1_ff <= pcm_in_valid;
			valid_s2_ff <= valid_s1_ff;
		end
	end

	// output samples are registered; they hold between valid pulses
	// holding avoids glitches
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pcm_out_left  <= '0;
			pcm_out_right <= '0;
		end else if (valid_s1_ff) begin
			pcm_out_left  <= nxt_left;
			pcm_out_right <= nxt_right;
		end
	end
	assign pcm_out_valid = valid_s2_ff;

endmodule

// ---- adm_properties.sv ----
// assertion checker for the status and mix register block, bound to its top module
module adm_checker
	import adm_pkg::*;
(
	input wire logic                     core_clk,
	input wire logic                     sys_rst,
	input wire logic                     soft_rst,
	input wire logic                     frame_sync,
	input wire logic [ADM_HDR_W-1:0]     frame_header_in,
	input wire logic                     pcm_in_valid,
	input wire logic                     pcm_out_valid,
	input wire logic [ADM_PLL_DIV_W-1:0] pll_out_divider_44k1,
	input wire logic [ADM_PLL_DIV_W:0]   pll_divide_ratio,
	input wire logic [15:0]              pll_fraction_44k1,
	input wire logic [7:0]               pll_fraction_44k1_high,
	input wire logic                     hdr_layer3_ok,
	input wire logic                     hdr_crc_present,
	input wire logic                     hdr_padding,
	input wire logic [1:0]               hdr_mode,
	input wire logic                     hdr_mode_ext_valid,
	input wire logic [1:0]               hdr_mode_ext,
	input wire logic [1:0]               hdr_emphasis,
	input wire logic                     hdr_emphasis_reserved
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	// pll figures follow the registers at once
	property p_div_ratio;
		pll_divide_ratio == {1'b0, pll_out_divider_44k1} + 6'h01;
	endproperty
	a_div_ratio: assert property (p_div_ratio) else $error("divide ratio is not divider plus one");
	property p_frac_high;
		pll_fraction_44k1[15:8] == pll_fraction_44k1_high;
	endproperty
	a_frac_high: assert property (p_frac_high) else $error("fraction upper byte mismatch");

	// header decodes track the captured header, soft reset wins over capture
	property p_layer;
		frame_sync && !soft_rst |=> hdr_layer3_ok == ($past(frame_header_in[18:17]) == 2'h1);
	endproperty
	a_layer: assert property (p_layer) else $error("layer flag wrong after capture");
	property p_crc;
		frame_sync && !soft_rst |=> hdr_crc_present != $past(frame_header_in[16]);
	endproperty
	a_crc: assert property (p_crc) else $error("checksum flag wrong after capture");
	property p_hdr_hold;
		!frame_sync && !soft_rst |=> $stable({hdr_mode, hdr_emphasis, hdr_padding});
	endproperty
	a_hdr_hold: assert property (p_hdr_hold) else $error("header changed without frame sync");
	property p_mode_ext;
		hdr_mode_ext_valid == (hdr_mode == 2'h1) && (hdr_mode_ext_valid || hdr_mode_ext == 2'h0);
	endproperty
	a_mode_ext: assert property (p_mode_ext) else $error("mode extension shown outside joint stereo");
	property p_emph;
		hdr_emphasis_reserved == (hdr_emphasis == 2'h2);
	endproperty
	a_emph: assert property (p_emph) else $error("reserved emphasis flag wrong");

	// mixer pipeline answers exactly two cycles after each sample
	property p_out_pulse;
		pcm_in_valid |-> ##2 pcm_out_valid;
	endproperty
	a_out_pulse: assert property (p_out_pulse) else $error("mixer output valid missing");
	property p_out_cause;
		pcm_out_valid |-> $past(pcm_in_valid, 2);
	endproperty
	a_out_cause: assert property (p_out_cause) else $error("mixer output valid without sample");
endmodule

bind adm_status_mix_regs adm_checker i_adm_checker (.core_clk(core_clk), .sys_rst(sys_rst), .soft_rst(soft_rst),
	.frame_sync(frame_sync), .frame_header_in(frame_header_in), .pcm_in_valid(pcm_in_valid),
	.pcm_out_valid(pcm_out_valid), .pll_out_divider_44k1(pll_out_divider_44k1),
	.pll_divide_ratio(pll_divide_ratio), .pll_fraction_44k1(pll_fraction_44k1),
	.pll_fraction_44k1_high(pll_fraction_44k1_high), .hdr_layer3_ok(hdr_layer3_ok),
	.hdr_crc_present(hdr_crc_present), .hdr_padding(hdr_padding), .hdr_mode(hdr_mode),
	.hdr_mode_ext_valid(hdr_mode_ext_valid), .hdr_mode_ext(hdr_mode_ext), .hdr_emphasis(hdr_emphasis),
	.hdr_emphasis_reserved(hdr_emphasis_reserved));

// ---- adm_host_model.sv ----
// host controller model driving the parallel register port
module adm_host_model (
	input  wire logic       core_clk,
	input  wire logic [7:0] reg_rdata,
	output logic [7:0]      reg_addr,
	output logic            reg_wr,
	output logic [7:0]      reg_wdata,
	output logic            reg_rd
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle bus at time zero
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// one write strobe across one rising edge; released lines are scrambled so stale values never pass
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge core_clk);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask

	// read data is loaded at the strobe edge and taken half a cycle later
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge core_clk);
		reg_rd = 1'b0;
		reg_addr = ~a;
		d = reg_rdata;
	endtask
endmodule

// ---- tb_audio_decoder_status_and_mix_regs.sv ----
// self-checking bench for the status, header and mixer register block
module tb_audio_decoder_status_and_mix_regs
	import adm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic core_clk = 1'b0, sys_rst = 1'b1, soft_rst = 1'b0, frame_sync = 1'b0, frame_ok = 1'b0, pcm_in_valid = 1'b0;
	logic [20:0] frame_header_in = 21'h0;
	logic [15:0] anc_bits_in = 16'h0000;
	logic [7:0] pll_fraction_44k1_high = 8'h00, reg_addr, reg_wdata, reg_rdata, d;
	logic reg_wr, reg_rd, pcm_out_valid, hdr_free_format, hdr_bitrate_forbidden, hdr_version_reserved;
	logic hdr_sample_rate_reserved, hdr_layer3_ok, hdr_crc_present, hdr_padding, hdr_private, hdr_mode_ext_valid;
	logic hdr_copyright, hdr_original, hdr_emphasis_reserved;
	logic signed [15:0] pcm_in_left = 16'sh0000, pcm_in_right = 16'sh0000, pcm_out_left, pcm_out_right, s;
	logic [4:0] pll_out_divider_44k1;
	logic [5:0] pll_divide_ratio;
	logic [15:0] pll_fraction_44k1, hdr_sample_rate_hz;
	logic [8:0] hdr_bitrate_kbps;
	logic [1:0] hdr_version, hdr_mode, hdr_mode_ext, hdr_emphasis;
	int mismatches = 0, samples_checked = 0, seed = 62952, i, l, dv;
	int att[4] = '{0, 255, 0, 255};
	int v1[16] = '{0, 32, 40, 48, 56, 64, 80, 96, 112, 128, 160, 192, 224, 256, 320, 0};
	int v0[16] = '{0, 8, 16, 24, 32, 40, 48, 56, 64, 80, 96, 112, 128, 144, 160, 0};
	int sfb[4] = '{44100, 48000, 32000, 0};
	logic [7:0] ra[12] = '{8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47, 8'h48, 8'h49, 8'h50, 8'h51, 8'h4a};
	logic [7:0] rv[12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00};
	logic [20:0] h;

	always #12.5 core_clk = ~core_clk;

	adm_status_mix_regs #(.PCM_W(16)) i_adm_status_mix_regs (.core_clk(core_clk), .sys_rst(sys_rst),
		.soft_rst(soft_rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .frame_sync(frame_sync), .frame_header_in(frame_header_in), .frame_ok(frame_ok),
		.anc_bits_in(anc_bits_in), .pll_fraction_44k1_high(pll_fraction_44k1_high), .pcm_in_valid(pcm_in_valid),
		.pcm_in_left(pcm_in_left), .pcm_in_right(pcm_in_right), .pcm_out_valid(pcm_out_valid),
		.pcm_out_left(pcm_out_left), .pcm_out_right(pcm_out_right), .pll_out_divider_44k1(pll_out_divider_44k1),
		.pll_divide_ratio(pll_divide_ratio), .pll_fraction_44k1(pll_fraction_44k1),
		.hdr_bitrate_kbps(hdr_bitrate_kbps), .hdr_free_format(hdr_free_format),
		.hdr_bitrate_forbidden(hdr_bitrate_forbidden), .hdr_version(hdr_version),
		.hdr_version_reserved(hdr_version_reserved), .hdr_sample_rate_hz(hdr_sample_rate_hz),
		.hdr_sample_rate_reserved(hdr_sample_rate_reserved), .hdr_layer3_ok(hdr_layer3_ok),
		.hdr_crc_present(hdr_crc_present), .hdr_padding(hdr_padding), .hdr_private(hdr_private),
		.hdr_mode(hdr_mode), .hdr_mode_ext_valid(hdr_mode_ext_valid), .hdr_mode_ext(hdr_mode_ext),
		.hdr_copyright(hdr_copyright), .hdr_original(hdr_original), .hdr_emphasis(hdr_emphasis),
		.hdr_emphasis_reserved(hdr_emphasis_reserved));

	adm_host_model i_adm_host_model (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd));

	// reference gain: 1 dB steps, six steps per halving, anything past 96 mutes
	function automatic int scale(int x, int c);
		int g[6] = '{32768, 29205, 26029, 23198, 20675, 18427};
		if (c > 96) return 0;
		return (x * g[c % 6]) >>> (15 + c / 6);
	endfunction

	function automatic int sat(int v);
		return (v > 32767) ? 32767 : ((v < -32768) ? -32768 : v);
	endfunction

	task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", n, exp, seen);
		end
	endtask

	task automatic rdchk(logic [7:0] a, logic [7:0] e);
		i_adm_host_model.rd(a, d);
		chk($sformatf("reg %h", a), d, e);
	endtask

	task automatic wratt(int k, int c);
		i_adm_host_model.wr(8'h46 + k[7:0], c[7:0]);
		att[k] = c;
	endtask

	// one sample through the butterfly; a missing valid counts as a mismatch
	task automatic pcm(int lv, int rv_);
		int k;
		@(negedge core_clk);
		pcm_in_left = lv[15:0];
		pcm_in_right = rv_[15:0];
		pcm_in_valid = 1'b1;
		@(negedge core_clk);
		pcm_in_valid = 1'b0;
		for (k = 0; k < 6 && pcm_out_valid !== 1'b1; k++) @(negedge core_clk);
		chk("pcm_out_valid", pcm_out_valid, 1);
		chk("pcm_out_left", pcm_out_left, sat(scale(lv, att[0]) + scale(rv_, att[3])));
		chk("pcm_out_right", pcm_out_right, sat(scale(rv_, att[2]) + scale(lv, att[1])));
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// main sequence
	initial begin
		repeat (10) @(negedge core_clk);
		sys_rst = 1'b0;
		foreach (ra[k]) rdchk(ra[k], rv[k]);
		pcm(1000, -2000);
		// attenuation codes: boundaries first, then random
		for (i = 0; i < 28; i++) begin
			l = (i == 6) ? 255 : ((i == 7) ? 97 : ((i < 6) ? i * 19 + (i == 5) : ($random(seed) & 32'h7f)));
			wratt(i % 4, l);
			s = $random(seed);
			l = s;
			s = $random(seed);
			pcm(l, s);
		end
		for (i = 0; i < 4; i++) wratt(i, 0);
		pcm(32767, 32767);
		pcm(-32768, -32768);
		// ancillary count capture, read-only and unmapped places
		@(negedge core_clk);
		anc_bits_in = $random(seed);
		frame_ok = 1'b1;
		@(negedge core_clk);
		frame_ok = 1'b0;
		i_adm_host_model.wr(8'h41, 8'h5a);
		i_adm_host_model.wr(8'h4a, 8'h5a);
		rdchk(8'h41, anc_bits_in[7:0]);
		rdchk(8'h42, anc_bits_in[15:8]);
		rdchk(8'h4a, 8'h00);
		// header capture, every bitrate, version, rate, mode and emphasis code visited
		for (i = 0; i < 16; i++) begin
			h = $random(seed);
			h[15:12] = i[3:0];
			h[20:19] = i[3:2];
			h[11:10] = i[1:0];
			h[7:6] = i[3:2];
			h[1:0] = i[1:0];
			if (i < 8) h[18:17] = 2'h1;
			@(negedge core_clk);
			frame_header_in = h;
			frame_sync = 1'b1;
			@(negedge core_clk);
			frame_sync = 1'b0;
			frame_header_in = ~h;
			dv = (h[20:19] == 2'h3) ? 1 : ((h[20:19] == 2'h2) ? 2 : ((h[20:19] == 2'h0) ? 4 : 0));
			chk("kbps", hdr_bitrate_kbps, h[19] ? v1[i] : v0[i]);
			chk("free", hdr_free_format, i == 0);
			chk("forbidden", hdr_bitrate_forbidden, i == 15);
			chk("version", hdr_version, h[20:19]);
			chk("rate", hdr_sample_rate_hz, dv ? sfb[h[11:10]] / dv : 0);
			chk("layer", hdr_layer3_ok, h[18:17] == 2'h1);
			chk("crc", hdr_crc_present, !h[16]);
			chk("pad", hdr_padding, h[9]);
			chk("mode", {hdr_private, hdr_mode}, {h[8], h[7:6]});
			chk("copy", {hdr_copyright, hdr_original, hdr_emphasis}, h[3:0]);
			chk("rsv", {hdr_version_reserved, hdr_sample_rate_reserved, hdr_emphasis_reserved, hdr_mode_ext_valid,
				hdr_mode_ext}, {dv == 0, h[11:10] == 2'h3 || dv == 0, h[1:0] == 2'h2, h[7:6] == 2'h1,
				h[7:6] == 2'h1 ? h[5:4] : 2'h0});
			rdchk(8'h43, {3'h0, h[20:16]});
			rdchk(8'h44, h[15:8]);
			rdchk(8'h45, h[7:0]);
		end
		// pll divider and fraction
		i_adm_host_model.wr(8'h50, 8'hff);
		rdchk(8'h50, 8'h1f);
		chk("ratio", {pll_out_divider_44k1, pll_divide_ratio}, {5'h1f, 6'h20});
		pll_fraction_44k1_high = $random(seed);
		i_adm_host_model.wr(8'h51, 8'ha5);
		rdchk(8'h51, 8'ha5);
		chk("fraction", pll_fraction_44k1, {pll_fraction_44k1_high, 8'ha5});
		// software reset restores the table
		i_adm_host_model.wr(8'h47, 8'h00);
		i_adm_host_model.wr(8'h46, 8'h10);
		@(negedge core_clk);
		soft_rst = 1'b1;
		@(negedge core_clk);
		soft_rst = 1'b0;
		foreach (ra[k]) rdchk(ra[k], rv[k]);
		complete_run();
	end
endmodule
